// ==== inc/dqcm_pkg.sv ====
package dqcm_pkg;

    // widths
    localparam int LBL_W = 15;
    localparam int B_W = 4;
    localparam int RAW_W = 9;
    localparam int OUT_W = 16;
    localparam int GAIN_W = 18;
    localparam int PROD_W = RAW_W + GAIN_W + 1;
    localparam int GAIN_SHIFT = 8;

    // pipeline depth from tone taken to point shown
    localparam int LATENCY = 2;

    // loading limits
    localparam logic [B_W-1:0] B_MIN = 4'h1;
    localparam logic [B_W-1:0] B_SMALL_ODD = 4'h3;
    localparam logic [B_W-1:0] B_CROSS_MIN = 4'h5;
    localparam logic [B_W-1:0] BMAX_FLOOR = 4'h8;
    localparam logic [B_W-1:0] BMAX_CEIL = 4'hF;

    typedef logic [GAIN_W-1:0] dqcm_gain_t;
    typedef logic signed [RAW_W-1:0] dqcm_raw_t;

    // per-loading gain, 2^18 / sqrt(mean point energy), gives rms 1024 after shift
    localparam dqcm_gain_t GAIN_TBL [0:15] = '{
        18'h00000, 18'h2D414, 18'h2D414, 18'h1A20C,
        18'h143D1, 18'h0E4F9, 18'h09E01, 18'h07115,
        18'h04E8A, 18'h0385E, 18'h02736, 18'h01C2A,
        18'h01399, 18'h00E14, 18'h009CC, 18'h0070A
    };

    // fixed points for one and three bits per tone, odd coordinates
    localparam dqcm_raw_t B1_X [0:1] = '{9'h001, 9'h1FF};
    localparam dqcm_raw_t B1_Y [0:1] = '{9'h001, 9'h1FF};
    localparam dqcm_raw_t B3_X [0:7] = '{
        9'h001, 9'h001, 9'h1FF, 9'h1FF, 9'h1FD, 9'h001, 9'h1FF, 9'h003
    };
    localparam dqcm_raw_t B3_Y [0:7] = '{
        9'h001, 9'h1FF, 9'h001, 9'h1FF, 9'h001, 9'h003, 9'h1FD, 9'h1FF
    };

endpackage

// ==== rtl/dqcm_mapper.sv ====
`timescale 1ns/1ps
module dqcm_mapper (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // configuration from initialization
    input wire logic dirUp,
    input wire logic [3:0] bMaxDown,
    input wire logic [3:0] bMaxUp,
    // tone from bit source
    input wire logic inValid,
    input wire logic [3:0] inBits,
    input wire logic [14:0] inLabel,
    // scaled point from gain stage
    output logic outValid,
    output logic signed [15:0] outX,
    output logic signed [15:0] outY,
    output logic outErr
);

    logic [3:0] limitSel;
    logic [3:0] limitNow;
    logic inErr;
    logic signed [8:0] rawXNext;
    logic signed [8:0] rawYNext;
    logic s1Valid_reg;
    logic s1Err_reg;
    logic [3:0] s1Bits_reg;
    logic [14:0] s1Label_reg;
    logic signed [8:0] s1X_reg;
    logic signed [8:0] s1Y_reg;
    logic signed [27:0] prodX;
    logic signed [27:0] prodY;
    logic signed [18:0] gainS;

    // even b: coordinate bits taken every other label bit, a 1 appended
    function automatic logic [8:0] evenCoord(input logic [14:0] v, input logic [3:0] b,
                                             input int off);
        logic [8:0] r;
        int i;
        r = 9'h001;
        for (int k = 0; k < 8; k++) begin
            i = off + 2 * k;
            if (i < int'(b)) begin
                r[k + 1] = v[i];
            end else begin
                r[k + 1] = r[k];
            end
        end
        return r;
    endfunction

    // odd b above 3: low bits from the label, then the two computed top bits
    function automatic logic [8:0] oddCoord(input logic [14:0] v, input logic [3:0] b,
                                            input int off, input logic [1:0] top);
        logic [8:0] r;
        int i;
        int used;
        r = 9'h001;
        used = 0;
        for (int k = 0; k < 8; k++) begin
            i = off + 2 * k;
            if (i <= int'(b) - 5 + off) begin
                r[k + 1] = v[i];
            end else begin
                r[k + 1] = (used == 0) ? top[0] : top[1];
                used = used + 1;
            end
        end
        return r;
    endfunction

    // top pairs {Xc,Xc-1,Yc,Yc-1} from label bits b-1..b-5
    function automatic logic [3:0] topBits(input logic [14:0] v, input logic [3:0] b);
        logic h;
        logic p;
        logic q;
        logic [1:0] tx;
        logic [1:0] ty;
        h = v[b - 4'h1];
        p = v[b - 4'h2];
        q = v[b - 4'h3];
        if (!h) begin
            tx = {p, p};
            ty = {q, q};
        end else if (p == q) begin
            tx = v[b - 4'h4] ? 2'h2 : 2'h1;
            ty = {p, p};
        end else begin
            tx = {p, p};
            ty = v[b - 4'h5] ? 2'h2 : 2'h1;
        end
        return {tx, ty};
    endfunction

    // limit is clamped so a bad negotiation cannot shrink support below 8
    always_comb begin
        limitSel = dirUp ? bMaxUp : bMaxDown;
        if (limitSel < dqcm_pkg::BMAX_FLOOR) begin
            limitNow = dqcm_pkg::BMAX_FLOOR;
        end else begin
            limitNow = limitSel;
        end
        inErr = (inBits < dqcm_pkg::B_MIN) || (inBits > limitNow);
    end

    always_comb begin
        logic [3:0] tb;
        tb = topBits(inLabel, inBits);
        rawXNext = 9'h001;
        rawYNext = 9'h001;
        if (inErr) begin
            rawXNext = 9'h000;
            rawYNext = 9'h000;
        end else if (inBits == dqcm_pkg::B_MIN) begin
            rawXNext = dqcm_pkg::B1_X[inLabel[0]];
            rawYNext = dqcm_pkg::B1_Y[inLabel[0]];
        end else if (inBits == dqcm_pkg::B_SMALL_ODD) begin
            rawXNext = dqcm_pkg::B3_X[inLabel[2:0]];
            rawYNext = dqcm_pkg::B3_Y[inLabel[2:0]];
        end else if (!inBits[0]) begin
            rawXNext = evenCoord(inLabel, inBits, 1);
            rawYNext = evenCoord(inLabel, inBits, 0);
        end else begin
            rawXNext = oddCoord(inLabel, inBits, 1, tb[3:2]);
            rawYNext = oddCoord(inLabel, inBits, 0, tb[1:0]);
        end
    end

    // stage one: raw grid point
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1Valid_reg <= 1'b0;
            s1Err_reg <= 1'b0;
            s1Bits_reg <= 4'h0;
            s1Label_reg <= 15'h0000;
            s1X_reg <= 9'h000;
            s1Y_reg <= 9'h000;
        end else begin
            s1Valid_reg <= inValid;
            s1Err_reg <= inValid && inErr;
            s1Bits_reg <= inBits;
            s1Label_reg <= inLabel;
            s1X_reg <= rawXNext;
            s1Y_reg <= rawYNext;
        end
    end

    // one multiplier pair shared by all sizes; gain table indexed by loading
    always_comb begin
        gainS = signed'({1'b0, dqcm_pkg::GAIN_TBL[s1Bits_reg]});
        prodX = s1X_reg * gainS;
        prodY = s1Y_reg * gainS;
    end

    // stage two: scaled point
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            outValid <= 1'b0;
            outErr <= 1'b0;
            outX <= 16'h0000;
            outY <= 16'h0000;
        end else begin
            outValid <= s1Valid_reg;
            outErr <= s1Err_reg;
            outX <= prodX[dqcm_pkg::GAIN_SHIFT +: 16];
            outY <= prodY[dqcm_pkg::GAIN_SHIFT +: 16];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_toneIn;
        inValid && !inErr;
    endsequence

    sequence s_pointOut;
        outValid && !outErr;
    endsequence

    sequence s_rawGood;
        s1Valid_reg && !s1Err_reg;
    endsequence

    a_fixed_latency: assert property (inValid |-> ##2 outValid)
        else $error("tone did not leave after two cycles");
    a_no_spurious: assert property (!inValid |-> ##2 !outValid)
        else $error("point produced without a tone");
    a_min_load: assert property (inValid && inBits == 4'h1 |-> ##2 s_pointOut)
        else $error("one bit tone rejected");
    a_limit_err: assert property (inValid && inBits > limitNow |-> ##2 outValid && outErr)
        else $error("loading above limit not flagged");
    a_limit_ok: assert property (s_toneIn ##0 (inBits == 4'h8) |-> ##2 s_pointOut)
        else $error("loading of eight refused");
    a_points_odd: assert property (s_rawGood |-> s1X_reg[0] && s1Y_reg[0])
        else $error("coordinate not odd");
    a_even_sign: assert property (s_rawGood ##0 (!s1Bits_reg[0]) |->
        s1X_reg[8] == s1Label_reg[s1Bits_reg - 4'h1] &&
        s1Y_reg[8] == s1Label_reg[s1Bits_reg - 4'h2])
        else $error("even sign bits wrong");
    a_even_four: assert property (s_rawGood ##0 (s1Bits_reg == 4'h4) |->
        s1X_reg == {{7{s1Label_reg[3]}}, s1Label_reg[1], 1'b1} &&
        s1Y_reg == {{7{s1Label_reg[2]}}, s1Label_reg[0], 1'b1})
        else $error("four bit point wrong");
    a_block_low: assert property (s_rawGood ##0 (s1Bits_reg >= 4'h4) |->
        s1X_reg[1] == s1Label_reg[1] && s1Y_reg[1] == s1Label_reg[0])
        else $error("label block expansion broken");
    a_odd_top: assert property (s_rawGood ##0 (s1Bits_reg[0] && s1Bits_reg >= 4'h5 &&
        !s1Label_reg[s1Bits_reg - 4'h1]) |->
        s1X_reg[8] == s1Label_reg[s1Bits_reg - 4'h2] &&
        s1Y_reg[8] == s1Label_reg[s1Bits_reg - 4'h3])
        else $error("odd top bits wrong");
    a_odd_split: assert property (s_rawGood ##0 (s1Bits_reg == 4'h5 &&
        s1Label_reg[4:2] == 3'h4) |-> s1X_reg == (s1Label_reg[1] ? 9'h1FB : 9'h005) &&
        s1Y_reg[8:2] == 7'h00)
        else $error("odd split rows wrong");
    a_small_table: assert property (s_rawGood ##0 (s1Bits_reg == 4'h1) |->
        s1X_reg == s1Y_reg)
        else $error("one bit point off table");
    a_scale_sign: assert property (s_rawGood |=> outX[15] == $past(s1X_reg[8], 1) &&
        outY[15] == $past(s1Y_reg[8], 1))
        else $error("scaling changed sign");

    // refused tones must still flow, as zero points flagged bad
    sequence s_rawBad;
        s1Valid_reg && s1Err_reg;
    endsequence

    sequence s_toneBad;
        inValid && inErr;
    endsequence

    a_err_zero: assert property (s_rawBad |-> s1X_reg == 9'h000 && s1Y_reg == 9'h000)
        else $error("refused tone gave a nonzero raw point");
    a_err_out: assert property (outValid && outErr |-> outX == 16'h0000 && outY == 16'h0000)
        else $error("refused tone gave a nonzero point");
    a_zero_load: assert property (inValid && inBits == 4'h0 |-> ##2 outValid && outErr)
        else $error("empty tone not flagged");
    a_err_stage: assert property (s_toneBad |=> s_rawBad)
        else $error("refused tone lost in stage one");
    a_good_stage: assert property (s_toneIn |=> s_rawGood)
        else $error("good tone lost in stage one");
    a_good_out: assert property (s_rawGood |=> s_pointOut)
        else $error("good tone lost in stage two");
    a_err_valid: assert property (outErr |-> outValid)
        else $error("error flag without a point");
    a_up_select: assert property (dirUp && bMaxUp >= 4'h8 |-> limitNow == bMaxUp)
        else $error("upstream limit not in force");
    a_down_select: assert property (!dirUp && bMaxDown >= 4'h8 |-> limitNow == bMaxDown)
        else $error("downstream limit not in force");
    a_even_two: assert property (s_rawGood ##0 (s1Bits_reg == 4'h2) |->
        s1X_reg == {{8{s1Label_reg[1]}}, 1'b1} &&
        s1Y_reg == {{8{s1Label_reg[0]}}, 1'b1})
        else $error("two bit point wrong");
    a_even_six: assert property (s_rawGood ##0 (s1Bits_reg == 4'h6) |->
        s1X_reg == {{6{s1Label_reg[5]}}, s1Label_reg[3], s1Label_reg[1], 1'b1} &&
        s1Y_reg == {{6{s1Label_reg[4]}}, s1Label_reg[2], s1Label_reg[0], 1'b1})
        else $error("six bit point wrong");
    a_odd_low: assert property (s_rawGood ##0 (s1Bits_reg == 4'h7) |->
        s1X_reg[2:0] == {s1Label_reg[3], s1Label_reg[1], 1'b1} &&
        s1Y_reg[2:0] == {s1Label_reg[2], s1Label_reg[0], 1'b1})
        else $error("seven bit low bits wrong");
    a_odd_cross: assert property (s_rawGood ##0 (s1Bits_reg == 4'h5 &&
        s1Label_reg[4:2] == 3'h5) |-> s1X_reg[8:2] == 7'h00 &&
        s1Y_reg == (s1Label_reg[0] ? 9'h1FB : 9'h005))
        else $error("odd cross rows wrong");
    a_odd_top_hi: assert property (s_rawGood ##0 (s1Bits_reg[0] && s1Bits_reg >= 4'h5 &&
        s1Label_reg[s1Bits_reg - 4'h1] &&
        s1Label_reg[s1Bits_reg - 4'h2] != s1Label_reg[s1Bits_reg - 4'h3]) |->
        s1X_reg[8] == s1Label_reg[s1Bits_reg - 4'h2])
        else $error("odd top pair with differing bits wrong");
    a_three_table: assert property (s_rawGood ##0 (s1Bits_reg == 4'h3) |->
        (s1X_reg == 9'h001 || s1X_reg == 9'h1FF || s1X_reg == 9'h003 || s1X_reg == 9'h1FD) &&
        (s1Y_reg == 9'h001 || s1Y_reg == 9'h1FF || s1Y_reg == 9'h003 || s1Y_reg == 9'h1FD))
        else $error("three bit point off table");
    a_one_sign: assert property (s_rawGood ##0 (s1Bits_reg == 4'h1) |->
        s1X_reg[8] == s1Label_reg[0])
        else $error("one bit point sign wrong");
    // smallest grid sets the scale: plus one lands on 724, minus one floors to -725
    a_scale_mag: assert property (s_rawGood ##0 (s1Bits_reg == 4'h2) |=>
        (outX == 16'h02D4 || outX == 16'hFD2B) && (outY == 16'h02D4 || outY == 16'hFD2B))
        else $error("two bit point scaled wrong");

endmodule

// ==== testbench/dqcm_bit_source.sv ====
`timescale 1ns/1ps
module dqcm_bit_source (
    // clock
    input wire logic clk,
    // tone to mapper
    output logic inValid,
    output logic [3:0] inBits,
    output logic [14:0] inLabel
);
    initial begin
        inValid = 1'b0;
        inBits = 4'h0;
        inLabel = 15'h0000;
    end
    // one whole tone per strobe, count and label together
    task automatic send(input logic [3:0] b, input logic [14:0] lbl);
        @(posedge clk);
        inValid <= 1'b1;
        inBits <= b;
        inLabel <= lbl;
    endtask
    // idle lines flip so a stale tone can never pass for a fresh one
    task automatic idle();
        @(posedge clk);
        inValid <= 1'b0;
        inBits <= ~inBits;
        inLabel <= ~inLabel;
    endtask
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic dirUp = 1'b0;
    logic [3:0] bMaxDown = 4'hF;
    logic [3:0] bMaxUp = 4'h8;
    wire logic inValid;
    wire logic [3:0] inBits;
    wire logic [14:0] inLabel;
    logic outValid;
    logic signed [15:0] outX;
    logic signed [15:0] outY;
    logic outErr;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int qx[$];
    int qy[$];
    int qe[$];
    int qc[$];
    // dir, down limit, up limit, b; limits below 8 probe the clamp
    localparam logic [15:0] LIM [0:8] = '{16'h1F99, 16'h1F9A, 16'h1F90, 16'h1F38,
        16'h1F39, 16'h0C8C, 16'h0C8D, 16'h02F8, 16'h02F9};

    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    dqcm_bit_source u_src (.clk(clk), .inValid(inValid), .inBits(inBits), .inLabel(inLabel));
    dqcm_mapper u_dut (.clk(clk), .reset(reset), .dirUp(dirUp), .bMaxDown(bMaxDown),
        .bMaxUp(bMaxUp), .inValid(inValid), .inBits(inBits), .inLabel(inLabel),
        .outValid(outValid), .outX(outX), .outY(outY), .outErr(outErr));

    function automatic void raw(input int b, input logic [14:0] v, output int x, output int y);
        logic [1:0] tx;
        logic [1:0] ty;
        int c;
        x = 1;
        y = 1;
        c = (b + 1) / 2;
        tx = v[b-1] ? ((v[b-2] == v[b-3]) ? (v[b-4] ? 2'h2 : 2'h1) : {2{v[b-2]}}) : {2{v[b-2]}};
        ty = v[b-1] ? ((v[b-2] == v[b-3]) ? {2{v[b-2]}} : (v[b-5] ? 2'h2 : 2'h1)) : {2{v[b-3]}};
        if (b == 1) begin
            x = dqcm_pkg::B1_X[v[0]];
            y = dqcm_pkg::B1_Y[v[0]];
        end else if (b == 3) begin
            x = dqcm_pkg::B3_X[v[2:0]];
            y = dqcm_pkg::B3_Y[v[2:0]];
        end else if (b % 2 == 0) begin
            for (int i = 1; i < b - 1; i += 2) x += int'(v[i]) << ((i + 1) / 2);
            for (int i = 0; i < b - 2; i += 2) y += int'(v[i]) << (i / 2 + 1);
            x -= int'(v[b-1]) << (b / 2);
            y -= int'(v[b-2]) << (b / 2);
        end else begin
            for (int i = 1; i <= b - 4; i += 2) x += int'(v[i]) << ((i + 1) / 2);
            for (int i = 0; i <= b - 5; i += 2) y += int'(v[i]) << (i / 2 + 1);
            x += (int'(tx[0]) << (c - 1)) - (int'(tx[1]) << c);
            y += (int'(ty[0]) << (c - 1)) - (int'(ty[1]) << c);
        end
    endfunction

    // expectation for a tone just launched; taken next edge, shown one edge after that
    task automatic push(input int b, input logic [14:0] lbl, input int lim);
        int x;
        int y;
        int g;
        raw(b, lbl, x, y);
        g = int'(dqcm_pkg::GAIN_TBL[b[3:0]]);
        qe.push_back((b == 0 || b > lim) ? 1 : 0);
        qx.push_back(qe[$] ? 0 : (x * g) >>> dqcm_pkg::GAIN_SHIFT);
        qy.push_back(qe[$] ? 0 : (y * g) >>> dqcm_pkg::GAIN_SHIFT);
        qc.push_back(cyc + 3);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic collect(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (outValid !== 1'b1 && k < 20);
            if (k >= 20) begin
                chk("outValid", 1, 0);
                results();
            end
            chk("cycle", qc.pop_front(), cyc);
            chk("outErr", 32'(qe.pop_front()), 32'(outErr));
            chk("outX", 32'(qx.pop_front()), 32'(outX));
            chk("outY", 32'(qy.pop_front()), 32'(outY));
        end
    endtask

    // loadings 1 to 15, all 32 top-bit patterns, junk above b, back to back
    task automatic sc_sweep();
        logic [14:0] lbl;
        fork
            begin
                for (int b = 1; b <= 15; b++) begin
                    for (int k = 0; k < 32; k++) begin
                        lbl = 15'((k << 10) | ((k * 683) & 32'h3FF)) >> (15 - b);
                        lbl = lbl | (k[0] ? (15'h7FFF << b) : 15'h0000);
                        u_src.send(4'(b), lbl);
                        push(b, lbl, 15);
                    end
                end
                u_src.idle();
            end
            collect(480);
        join
    endtask

    // direction select and clamp, limits changing tone by tone
    task automatic sc_limits();
        int lim;
        fork
            begin
                foreach (LIM[i]) begin
                    u_src.send(LIM[i][3:0], 15'h5A5A);
                    dirUp <= LIM[i][12];
                    bMaxDown <= LIM[i][11:8];
                    bMaxUp <= LIM[i][7:4];
                    lim = LIM[i][12] ? LIM[i][7:4] : LIM[i][11:8];
                    push(LIM[i][3:0], 15'h5A5A, (lim < 8) ? 8 : lim);
                end
                u_src.idle();
            end
            collect(9);
        join
    endtask

    task automatic results();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        sc_sweep();
        sc_limits();
        results();
    end
endmodule
